/* hw/pm_cfg_pkg.sv */
package pm_cfg_pkg;
  // configuration byte addresses, pm and general control dword-aligned
  localparam logic [7:0] PM_CS_OFS   = 8'h48;
  localparam logic [7:0] BSE_OFS     = 8'h4a;
  localparam logic [7:0] PDATA_OFS   = 8'h4b;
  localparam logic [7:0] GCTL_OFS    = 8'h4c;
  // power management control/status field positions
  localparam int WAKE_FLAG_BIT   = 15;
  localparam int WAKE_EN_BIT     = 8;
  localparam int PLEVEL_LSB      = 0;
  // general control field positions
  localparam int INTSEL_LSB      = 5;
  localparam int COLD_CTL_BIT    = 4;
  localparam int SDMMC_OFF_BIT   = 1;
  localparam int STICK_OFF_BIT   = 0;
  // reset values
  localparam logic [15:0] PM_CS_RST  = 16'h0000;
  localparam logic [7:0]  GCTL_RST   = 8'h00;
  localparam logic [7:0]  BSE_VAL    = 8'h00;
  localparam logic [7:0]  PDATA_VAL  = 8'h00;
  // auxiliary current codes
  localparam logic [2:0]  AUX_SELF   = 3'h0;
  localparam logic [2:0]  AUX_55MA   = 3'h1;
  // socket capability flag width
  localparam int CAP_W = 4;
  typedef enum logic [1:0] {
    LVL_D0     = 2'h0,
    LVL_D1     = 2'h1,
    LVL_D2     = 2'h2,
    LVL_D3_HOT = 2'h3
  } power_level_e;
endpackage : pm_cfg_pkg

/* hw/flash_media_pm_config.sv */
`timescale 1ns/1ps
// Functional notes
// - d3hot-to-d0 internal reset leaves pm register alone
// - wake flag at bit 15, resets to zero
// - power report scale and selector read zero
// - wake enable bit 8 gates wake signalling
// - two-bit power level field, d0..d3hot
// - pm register bits 7..2 read zero
// - marked fields cleared only by global reset
// - bridge extension and power data read zero
// - interrupt choice field selects inta..intd
// - override terminals make interrupt choice ignored
// - cold wake control copies into capability flag
// - aux current 000b clear, 001b set
// - sdmmc off reports sd/mmc card unsupported
// - sdmmc off forces sd capability flags zero
// - stick off reports stick card unsupported
// - stick off forces stick capability flags zero
// - general control bits 7,3,2 read zero
module flash_media_pm_config
(
  input  wire logic                       sys_clk,                // configuration clock
  input  wire logic                       srst,                   // ordinary reset, active high
  input  wire logic                       global_reset_pin_n,     // global reset, active low
  input  wire logic [7:0]                 cfg_addr,               // byte address, low two bits ignored
  input  wire logic                       cfg_rd,                 // read strobe
  input  wire logic                       cfg_wr,                 // write strobe
  input  wire logic [3:0]                 cfg_be,                 // byte enables
  input  wire logic [31:0]                cfg_wdata,              // write data
  output logic [31:0]                     cfg_rdata,              // read data, one cycle after cfg_rd
  output logic                            cfg_ack,                // read/write done pulse
  input  wire logic                       wake_event,             // wake source, one-cycle pulse
  output logic                            wake_out_n,             // wake signalling, active low
  output logic [1:0]                      power_level_field,      // current power level
  output logic                            func_reset,             // d3hot-to-d0 internal reset pulse
  input  wire logic [3:0]                 interrupt_pin_override, // override terminals, one per line
  input  wire logic                       int_request,            // function interrupt request
  output logic [3:0]                      int_out_n,              // inta..intd, active low
  output logic [7:0]                      int_pin_code,           // interrupt pin register value
  output logic                            cold_wake_support_flag, // capability bit 15
  output logic [2:0]                      aux_current,            // capability bits 8..6
  input  wire logic                       card_present,           // a card sits in the socket
  input  wire logic                       card_is_sdmmc,          // inserted card is sd or mmc
  input  wire logic                       card_is_stick,          // inserted card is stick format
  output logic                            card_unsupported,       // report card as unsupported
  input  wire logic [pm_cfg_pkg::CAP_W-1:0] sd_caps_raw,          // sd flags before masking
  input  wire logic [pm_cfg_pkg::CAP_W-1:0] stick_caps_raw,       // stick flags before masking
  output logic [pm_cfg_pkg::CAP_W-1:0]    sd_capable_flags,       // socket enumeration sd flags
  output logic [pm_cfg_pkg::CAP_W-1:0]    stick_capable_flags     // socket enumeration stick flags
);
  import pm_cfg_pkg::*;

  logic                 glob_rst;        // global reset, active high
  logic                 wake_event_flag_q;  // sticky wake status
  logic                 wake_signal_enable_q; // wake enable
  power_level_e         plevel_q;        // power level field
  logic [1:0]           int_choice_q;    // interrupt line choice
  logic                 cold_ctl_q;      // cold wake capable control
  logic                 sdmmc_off_q;     // sd/mmc support off
  logic                 stick_off_q;     // stick support off
  logic [31:0]          rdata_q;         // registered read data
  logic                 ack_q;           // access completion
  logic                 func_reset_q;    // internal reset pulse
  logic [1:0]           int_sel;         // effective interrupt line
  logic                 pm_wr;           // write to pm dword
  logic                 gc_wr;           // write to general control dword

  assign glob_rst = ~global_reset_pin_n;

  // dword decode, shared by read and write paths
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a[7:2] == ofs[7:2]);
  endfunction : hit

  assign pm_wr = cfg_wr && hit(cfg_addr, PM_CS_OFS);
  assign gc_wr = cfg_wr && hit(cfg_addr, GCTL_OFS);

  // wake status: set wins over a simultaneous write-one clear
  always_ff @(posedge sys_clk) begin
    if (glob_rst) begin
      wake_event_flag_q <= PM_CS_RST[WAKE_FLAG_BIT];
    end else if (wake_event) begin
      wake_event_flag_q <= 1'b1;
    end else if (pm_wr && cfg_be[1] && cfg_wdata[WAKE_FLAG_BIT]) begin
      wake_event_flag_q <= 1'b0;
    end
  end

  // pm control fields; srst and the internal reset do not touch them
  always_ff @(posedge sys_clk) begin
    if (glob_rst) begin
      wake_signal_enable_q <= PM_CS_RST[WAKE_EN_BIT];
      plevel_q             <= LVL_D0;
    end else if (pm_wr) begin
      if (cfg_be[1]) begin
        wake_signal_enable_q <= cfg_wdata[WAKE_EN_BIT];
      end
      if (cfg_be[0]) begin
        plevel_q <= power_level_e'(cfg_wdata[PLEVEL_LSB +: 2]);
      end
    end
  end

  // general control fields
  always_ff @(posedge sys_clk) begin
    if (glob_rst) begin
      int_choice_q <= GCTL_RST[INTSEL_LSB +: 2];
      cold_ctl_q   <= GCTL_RST[COLD_CTL_BIT];
      sdmmc_off_q  <= GCTL_RST[SDMMC_OFF_BIT];
      stick_off_q  <= GCTL_RST[STICK_OFF_BIT];
    end else if (gc_wr && cfg_be[0]) begin
      int_choice_q <= cfg_wdata[INTSEL_LSB +: 2];
      cold_ctl_q   <= cfg_wdata[COLD_CTL_BIT];
      sdmmc_off_q  <= cfg_wdata[SDMMC_OFF_BIT];
      stick_off_q  <= cfg_wdata[STICK_OFF_BIT];
    end
  end

  // internal reset pulse on leaving d3hot for d0; it resets the function
  // core outside this block, the pm register deliberately ignores it
  always_ff @(posedge sys_clk) begin
    if (srst || glob_rst) begin
      func_reset_q <= 1'b0;
    end else begin
      func_reset_q <= pm_wr && cfg_be[0] && (plevel_q == LVL_D3_HOT)
                      && (cfg_wdata[PLEVEL_LSB +: 2] == LVL_D0);
    end
  end

  // read image of each dword; unmapped dwords read zero
  function automatic logic [31:0] rd_word(input logic [7:0] a);
    logic [31:0] w;
    w = 32'h0000_0000;
    if (hit(a, PM_CS_OFS)) begin
      w[WAKE_FLAG_BIT]        = wake_event_flag_q;
      w[WAKE_EN_BIT]          = wake_signal_enable_q;
      w[PLEVEL_LSB +: 2]      = plevel_q;
      w[23:16]                = BSE_VAL;
      w[31:24]                = PDATA_VAL;
    end else if (hit(a, GCTL_OFS)) begin
      w[INTSEL_LSB +: 2]      = int_choice_q;
      w[COLD_CTL_BIT]         = cold_ctl_q;
      w[SDMMC_OFF_BIT]        = sdmmc_off_q;
      w[STICK_OFF_BIT]        = stick_off_q;
    end
    // scale/select bits 14..9, bits 7..2 and general bits 7,3,2 stay zero
    rd_word = w;
  endfunction : rd_word

  // read data registered so it is stable for the host
  always_ff @(posedge sys_clk) begin
    if (srst || glob_rst) begin
      rdata_q <= 32'h0000_0000;
    end else if (cfg_rd) begin
      rdata_q <= rd_word(cfg_addr);
    end
  end

  // completion pulse one cycle after any access
  always_ff @(posedge sys_clk) begin
    if (srst || glob_rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= cfg_rd || cfg_wr;
    end
  end

  // effective interrupt line: override terminals win, lowest first
  always_comb begin
    if (interrupt_pin_override[0]) begin
      int_sel = 2'h0;
    end else if (interrupt_pin_override[1]) begin
      int_sel = 2'h1;
    end else if (interrupt_pin_override[2]) begin
      int_sel = 2'h2;
    end else if (interrupt_pin_override[3]) begin
      int_sel = 2'h3;
    end else begin
      int_sel = int_choice_q;
    end
  end

  assign cfg_rdata              = rdata_q;
  assign cfg_ack                = ack_q;
  assign func_reset             = func_reset_q;
  assign power_level_field      = plevel_q;
  // flag stays set when disabled; only the pin is held off
  assign wake_out_n             = ~(wake_event_flag_q && wake_signal_enable_q);
  assign int_pin_code           = {6'h00, int_sel} + 8'h01;
  assign int_out_n              = ~({3'h0, int_request} << int_sel);
  assign cold_wake_support_flag = cold_ctl_q;
  assign aux_current            = cold_ctl_q ? AUX_55MA : AUX_SELF;
  assign card_unsupported       = card_present && ((card_is_sdmmc && sdmmc_off_q)
                                  || (card_is_stick && stick_off_q));
  assign sd_capable_flags       = sdmmc_off_q ? '0 : sd_caps_raw;
  assign stick_capable_flags    = stick_off_q ? '0 : stick_caps_raw;

  // checks, by default disabled while either reset is applied
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst || glob_rst);

  property p_flag_set;
    wake_event |=> wake_event_flag_q;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("wake flag not set by event");

  property p_flag_clr;
    pm_wr && cfg_be[1] && cfg_wdata[15] && !wake_event |=> !wake_event_flag_q;
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("wake flag not cleared by write one");

  property p_wake_gate;
    !wake_signal_enable_q |-> wake_out_n;
  endproperty
  a_wake_gate: assert property (p_wake_gate) else $error("wake signalled while disabled");

  // the d3hot-to-d0 pulse must not disturb any pm field on its own
  property p_level_hold;
    func_reset && !pm_wr && !wake_event |=> $stable(plevel_q) && $stable(wake_signal_enable_q)
      && $stable(wake_event_flag_q);
  endproperty
  a_level_hold: assert property (p_level_hold) else $error("pm state disturbed by internal reset");

  property p_rd_zero;
    cfg_rd && hit(cfg_addr, PM_CS_OFS) |=> cfg_rdata[14:9] == 6'h00 && cfg_rdata[7:2] == 6'h00
                                         && cfg_rdata[31:16] == 16'h0000 && cfg_ack;
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("pm reserved or unimplemented bits nonzero");

  property p_gc_zero;
    cfg_rd && hit(cfg_addr, GCTL_OFS) |=> cfg_rdata[7] == 1'b0 && cfg_rdata[3:2] == 2'h0;
  endproperty
  a_gc_zero: assert property (p_gc_zero) else $error("general control reserved bits nonzero");

  property p_level_wr;
    pm_wr && cfg_be[0] |=> plevel_q == $past(cfg_wdata[1:0]);
  endproperty
  a_level_wr: assert property (p_level_wr) else $error("power level not written");

  property p_override;
    interrupt_pin_override[1] && !interrupt_pin_override[0] |-> int_pin_code == 8'h02;
  endproperty
  a_override: assert property (p_override) else $error("override terminal not honoured");

  property p_aux;
    aux_current == (cold_wake_support_flag ? 3'h1 : 3'h0);
  endproperty
  a_aux: assert property (p_aux) else $error("aux current wrong");

  // a disabled card kind must look absent from enumeration and be refused
  property p_caps;
    sdmmc_off_q |-> sd_capable_flags == '0;
  endproperty
  a_caps: assert property (p_caps) else $error("sd_capable_flags not disabled");

  property p_sd_unsup;
    sdmmc_off_q && card_present && card_is_sdmmc |-> card_unsupported;
  endproperty
  a_sd_unsup: assert property (p_sd_unsup) else $error("sd card not reported unsupported");

  property p_stick;
    stick_off_q |-> stick_capable_flags == '0;
  endproperty
  a_stick: assert property (p_stick) else $error("stick support not disabled");

  property p_stick_unsup;
    stick_off_q && card_present && card_is_stick |-> card_unsupported;
  endproperty
  a_stick_unsup: assert property (p_stick_unsup) else $error("stick card not reported unsupported");

  // writing zero to the status bit must leave it set
  property p_flag_keep;
    pm_wr && cfg_be[1] && !cfg_wdata[WAKE_FLAG_BIT] && wake_event_flag_q |=> wake_event_flag_q;
  endproperty
  a_flag_keep: assert property (p_flag_keep) else $error("wake flag cleared by write zero");

  property p_en_wr;
    pm_wr && cfg_be[1] |=> wake_signal_enable_q == $past(cfg_wdata[WAKE_EN_BIT]);
  endproperty
  a_en_wr: assert property (p_en_wr) else $error("wake enable not written");

  property p_cold_copy;
    gc_wr && cfg_be[0] |=> cold_wake_support_flag == $past(cfg_wdata[COLD_CTL_BIT]);
  endproperty
  a_cold_copy: assert property (p_cold_copy) else $error("cold wake control not copied");

  // with no override asserted the programmed choice alone picks the line
  property p_int_line;
    interrupt_pin_override == 4'h0 |-> int_pin_code == 8'(int_choice_q) + 8'h01;
  endproperty
  a_int_line: assert property (p_int_line) else $error("interrupt choice not honoured");

  // the ordinary reset must leave every pm and general field as it was;
  // these two carry their own disable so that each reset is watched
  // while the other one is idle
  property p_srst_keep;
    disable iff (glob_rst)
    srst && !pm_wr && !gc_wr && !wake_event |=> $stable(plevel_q) && $stable(wake_signal_enable_q)
      && $stable(wake_event_flag_q) && $stable(int_choice_q)
      && $stable(cold_ctl_q) && $stable(sdmmc_off_q) && $stable(stick_off_q);
  endproperty
  a_srst_keep: assert property (p_srst_keep) else $error("ordinary reset disturbed a field");

  property p_global_reset_pin_clr;
    disable iff (srst)
    glob_rst |=> plevel_q == LVL_D0 && !wake_signal_enable_q && !wake_event_flag_q && int_choice_q == 2'h0
      && !cold_ctl_q && !sdmmc_off_q && !stick_off_q;
  endproperty
  a_global_reset_pin_clr: assert property (p_global_reset_pin_clr) else $error("global reset left a field set");

endmodule : flash_media_pm_config

/* bench/cfg_host_model.sv */
`timescale 1ns/1ps
// host side of the configuration path; drives at the falling edge
module cfg_host_model (
  input  wire logic        sys_clk,   // shared clock
  output logic             cfg_rd,    // read strobe
  output logic             cfg_wr,    // write strobe
  output logic [3:0]       cfg_be,    // byte enables
  output logic [7:0]       cfg_addr,  // byte address
  output logic [31:0]      cfg_wdata, // write data
  input  wire logic [31:0] cfg_rdata, // read data
  input  wire logic        cfg_ack    // completion pulse
);
  // idle bus before the first access
  initial begin
    cfg_rd = 1'b0;
    cfg_wr = 1'b0;
    cfg_be = 4'h0;
    cfg_addr = 8'h00;
    cfg_wdata = 32'h0;
  end

  // one access: strobe held over the taking edge, answer taken a cycle on
  task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] be,
                      input logic [31:0] d, output logic [31:0] q, output logic ok);
    @(negedge sys_clk);
    cfg_rd = !w;
    cfg_wr = w;
    cfg_be = be;
    cfg_addr = a;
    cfg_wdata = d;
    @(negedge sys_clk);
    ok = cfg_ack;
    q = cfg_rdata;
    cfg_rd = 1'b0;
    cfg_wr = 1'b0;
    // released lines flip so a stale value never looks valid
    cfg_addr = ~a;
    cfg_wdata = ~d;
  endtask : xfer
endmodule : cfg_host_model

/* bench/flash_media_pm_config_test.sv */
`timescale 1ns/1ps
module flash_media_pm_config_test;
  import pm_cfg_pkg::*;
  logic        sys_clk = 0, srst = 1, global_reset_pin_n = 0;     // clock and resets
  logic        wake_event = 0, int_request = 0, card_present = 0; // stimulus levels
  logic        card_is_sdmmc = 0, card_is_stick = 0;              // card kind
  logic [3:0]  interrupt_pin_override = 0;                        // override terminals
  logic [3:0]  sd_caps_raw = 4'ha, stick_caps_raw = 4'h5;         // raw socket flags
  logic        cfg_rd, cfg_wr, cfg_ack, wake_out_n, func_reset;   // bus and pulses
  logic        cold_wake_support_flag, card_unsupported;          // status outputs
  logic [3:0]  cfg_be, int_out_n, sd_capable_flags, stick_capable_flags;
  logic [7:0]  cfg_addr, int_pin_code;                            // address, pin code
  logic [31:0] cfg_wdata, cfg_rdata;                              // data paths
  logic [1:0]  power_level_field;                                 // current level
  logic [2:0]  aux_current;                                       // aux current code
  int          num_errors = 0, checks_done = 0, cyc = 0;          // counters

  always #12.5 sys_clk = ~sys_clk;

  flash_media_pm_config dut_u (.sys_clk, .srst, .global_reset_pin_n, .cfg_addr, .cfg_rd, .cfg_wr,
    .cfg_be, .cfg_wdata, .cfg_rdata, .cfg_ack, .wake_event, .wake_out_n, .power_level_field,
    .func_reset, .interrupt_pin_override, .int_request, .int_out_n, .int_pin_code,
    .cold_wake_support_flag, .aux_current, .card_present, .card_is_sdmmc, .card_is_stick,
    .card_unsupported, .sd_caps_raw, .stick_caps_raw, .sd_capable_flags, .stick_capable_flags);

  cfg_host_model host_u (.sys_clk, .cfg_rd, .cfg_wr, .cfg_be, .cfg_addr, .cfg_wdata,
    .cfg_rdata, .cfg_ack);

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim

  // hang guard: the tests need well under a thousand cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      end_sim();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // a write must be acknowledged one cycle after it is taken
  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    logic [31:0] q;
    logic ok;
    host_u.xfer(1'b1, a, be, d, q, ok);
    chk(ok, 1);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    logic ok;
    host_u.xfer(1'b0, a, 4'hf, 32'h0, q, ok);
    chk(ok, 1);
    chk(q, e);
  endtask : rd

  task automatic pulse_wake();
    @(negedge sys_clk) wake_event = 1;
    @(negedge sys_clk) wake_event = 0;
  endtask : pulse_wake

  initial begin
    repeat (4) @(negedge sys_clk);
    srst = 0;
    global_reset_pin_n = 1;
    rd(PM_CS_OFS, 32'h0);
    rd(GCTL_OFS, 32'h0);
    chk(wake_out_n, 1);
    $display("test reset done");
    // every level code, then all ones to reach read-only bits
    for (int i = 0; i < 4; i++) begin
      wr(PM_CS_OFS, 4'h1, 32'(i));
      chk(power_level_field, 32'(i));
    end
    wr(PM_CS_OFS, 4'hf, 32'hffff_ffff);
    rd(PM_CS_OFS, 32'h0000_0103);
    rd(BSE_OFS, 32'h0000_0103);
    // leaving the hot level raises the internal reset but keeps the register
    wr(PM_CS_OFS, 4'h1, 32'h0);
    chk(func_reset, 1);
    rd(PM_CS_OFS, 32'h0000_0100);
    $display("test level done");
    pulse_wake();
    rd(PM_CS_OFS, 32'h0000_8100);
    chk(wake_out_n, 0);
    wr(PM_CS_OFS, 4'h2, 32'h0000_0100);
    rd(PM_CS_OFS, 32'h0000_8100);
    wr(PM_CS_OFS, 4'h2, 32'h0000_8000);
    rd(PM_CS_OFS, 32'h0);
    pulse_wake();
    chk(wake_out_n, 1);
    wr(PM_CS_OFS, 4'h3, 32'h0000_0102);
    @(negedge sys_clk) srst = 1;
    @(negedge sys_clk) srst = 0;
    rd(PM_CS_OFS, 32'h0000_8102);
    $display("test wake done");
    // interrupt line choice, then override terminals
    int_request = 1;
    for (int i = 0; i < 4; i++) begin
      wr(GCTL_OFS, 4'h1, 32'(i << 5));
      chk(int_pin_code, 32'(i + 1));
      chk(int_out_n, 32'(4'(~(4'h1 << i))));
    end
    wr(GCTL_OFS, 4'hf, 32'hffff_ffff);
    rd(GCTL_OFS, 32'h73);
    @(negedge sys_clk) interrupt_pin_override = 4'h6;
    @(negedge sys_clk) chk(int_pin_code, 2);
    chk(int_out_n, 32'hd);
    interrupt_pin_override = 0;
    chk(cold_wake_support_flag, 1);
    chk(aux_current, 32'(AUX_55MA));
    $display("test interrupt done");
    // both card kinds switched off, then one at a time
    card_present = 1;
    card_is_sdmmc = 1;
    @(negedge sys_clk) chk(card_unsupported, 1);
    chk(sd_capable_flags, 0);
    chk(stick_capable_flags, 0);
    wr(GCTL_OFS, 4'h1, 32'h01);
    chk(card_unsupported, 0);
    chk(sd_capable_flags, 32'ha);
    chk(aux_current, 32'(AUX_SELF));
    card_is_sdmmc = 0;
    card_is_stick = 1;
    @(negedge sys_clk) chk(card_unsupported, 1);
    wr(GCTL_OFS, 4'h1, 32'h02);
    chk(card_unsupported, 0);
    chk(stick_capable_flags, 32'h5);
    chk(sd_capable_flags, 0);
    $display("test card done");
    wr(8'h50, 4'hf, 32'hffff_ffff);
    rd(8'h50, 32'h0);
    @(negedge sys_clk) global_reset_pin_n = 0;
    @(negedge sys_clk) global_reset_pin_n = 1;
    rd(PM_CS_OFS, 32'h0);
    rd(GCTL_OFS, 32'h0);
    $display("test global reset done");
    end_sim();
  end
endmodule : flash_media_pm_config_test
